// *** rail_seq_pkg.sv ***
`default_nettype none
package rail_seq_pkg;
   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] SUBADDR_SLOT_SW = 8'h25;
   localparam logic [7:0] SUBADDR_SLOT_GP = 8'h26;
   localparam logic [7:0] SUBADDR_UNLOCK = 8'h10;
   localparam logic [7:0] RESET_SLOT_SW = 8'h88;
   localparam logic [7:0] RESET_SLOT_GP = 8'h08;
   localparam int FIELD_W = 4;
   localparam int FIELD_HI_POS = 4;
   localparam int FIELD_LO_POS = 0;
   localparam int RAIL_COUNT = 4;

   // ------------------------------------------------------------------
   // step codes
   // ------------------------------------------------------------------
   localparam logic [3:0] STEP_FIRST = 4'h3;
   localparam logic [3:0] STEP_LAST = 4'ha;

   // a code outside the step range never matches any step
   function automatic logic step_hit(input logic [3:0] code, input logic [3:0] step);
      step_hit = (code >= STEP_FIRST) && (code <= STEP_LAST) && (code == step);
   endfunction

   function automatic logic code_sequenced(input logic [3:0] code);
      code_sequenced = (code >= STEP_FIRST) && (code <= STEP_LAST);
   endfunction
endpackage
`default_nettype wire

// *** rail_step_if.sv ***
`default_nettype none
// step assignment fields and the current step, out to the matcher and back
interface rail_step_if;
   logic [3:0] field [4];
   logic [3:0] step;
   logic strobe;
   logic [3:0] hit;
   modport ask(output field, output step, output strobe, input hit);
   modport match(input field, input step, input strobe, output hit);
endinterface
`default_nettype wire

// *** rail_step_match.sv ***
`default_nettype none
module rail_step_match (
   input wire logic clk,
   input wire logic rst_n,
   rail_step_if.match bus
);
   // ------------------------------------------------------------------
   // per rail step comparison
   // ------------------------------------------------------------------
   // purely combinational so a step strobe reaches the rail flops in one cycle
   always_comb begin
      for (int i = 0; i < rail_seq_pkg::RAIL_COUNT; i++) begin
         bus.hit[i] = bus.strobe && rail_seq_pkg::step_hit(bus.field[i], bus.step);
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_hit_equals_step: assert property (bus.hit[0] |-> bus.strobe &&
      bus.field[0] == bus.step && bus.step >= 4'h3 && bus.step <= 4'ha)
      else $error("rail 0 hit without a matching step code");
   a_in_range_hits: assert property ((bus.strobe && bus.field[1] == bus.step &&
      bus.step >= 4'h3 && bus.step <= 4'ha) |-> bus.hit[1])
      else $error("rail 1 missed its step");
   a_unsequenced_no_hit: assert property ((bus.field[3] < 4'h3 ||
      bus.field[3] > 4'ha) |-> !bus.hit[3])
      else $error("unsequenced rail 3 matched a step");
endmodule
`default_nettype wire

// *** rail_sequence_slot_regs.sv ***
`default_nettype none
module rail_sequence_slot_regs #(
   parameter logic [6:0] TARGET_ADDR = 7'h2a,
   parameter logic [7:0] UNLOCK_KEY = 8'h5a
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic step_strobe,
   input wire logic [3:0] step_num,
   input wire logic seq_clear,
   output logic [3:0] rail_on
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } link_state_t;

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_q <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_q <= sda_s;
      end
   end

   logic scl_rise, scl_fall, start_seen, stop_seen;
   // edges and bus conditions only from the second stage onward
   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign start_seen = scl_s && scl_q && sda_q && !sda_s;
   assign stop_seen = scl_s && scl_q && !sda_q && sda_s;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   link_state_t st, next_st;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sh, next_sh;
   logic [7:0] ptr, next_ptr;
   logic rw, next_rw;
   logic nack, next_nack;
   logic next_oe;
   logic [7:0] slot_sw, next_slot_sw;
   logic [7:0] slot_gp, next_slot_gp;
   logic unlocked, next_unlocked;
   logic [3:0] next_rail_on;
   logic wr_fire;

   rail_step_if bus ();
   assign bus.field[0] = slot_sw[rail_seq_pkg::FIELD_HI_POS +: rail_seq_pkg::FIELD_W];
   assign bus.field[1] = slot_sw[rail_seq_pkg::FIELD_LO_POS +: rail_seq_pkg::FIELD_W];
   assign bus.field[2] = slot_gp[rail_seq_pkg::FIELD_LO_POS +: rail_seq_pkg::FIELD_W];
   assign bus.field[3] = slot_gp[rail_seq_pkg::FIELD_HI_POS +: rail_seq_pkg::FIELD_W];
   assign bus.step = step_num;
   assign bus.strobe = step_strobe;

   rail_step_match u_match (
      .clk(clk),
      .rst_n(rst_n),
      .bus(bus)
   );

   // unmapped subaddresses read as zero; the unlock address shows the latch
   function automatic logic [7:0] read_byte(input logic [7:0] a);
      if (a == rail_seq_pkg::SUBADDR_SLOT_SW) read_byte = slot_sw;
      else if (a == rail_seq_pkg::SUBADDR_SLOT_GP) read_byte = slot_gp;
      else if (a == rail_seq_pkg::SUBADDR_UNLOCK) read_byte = {7'h00, unlocked};
      else read_byte = 8'h00;
   endfunction

   // ------------------------------------------------------------------
   // next state: link, registers, rails
   // ------------------------------------------------------------------
   // data is sampled on scl rise and changed on scl fall, so the target
   // never moves sda while scl is high and cannot fake a start or stop
   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_sh = sh;
      next_ptr = ptr;
      next_rw = rw;
      next_nack = nack;
      next_oe = sda_oe;
      next_slot_sw = slot_sw;
      next_slot_gp = slot_gp;
      next_unlocked = unlocked;
      next_rail_on = rail_on;
      wr_fire = 1'b0;
      if (start_seen) begin
         next_st = ST_ADDR;
         next_cnt = 4'h0;
         next_oe = 1'b0;
      end else if (stop_seen) begin
         next_st = ST_IDLE;
         next_oe = 1'b0;
      end else begin
         case (st)
            ST_ADDR, ST_SUB, ST_WR: begin
               if (scl_rise) begin
                  next_sh = {sh[6:0], sda_s};
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  next_cnt = 4'h0;
                  if (st == ST_ADDR) begin
                     if (sh[7:1] == TARGET_ADDR) begin
                        next_rw = sh[0];
                        next_oe = 1'b1;
                        next_st = ST_ADDR_ACK;
                     end else begin
                        next_st = ST_IDLE;
                     end
                  end else if (st == ST_SUB) begin
                     next_ptr = sh;
                     next_oe = 1'b1;
                     next_st = ST_SUB_ACK;
                  end else begin
                     wr_fire = 1'b1;
                     next_ptr = ptr + 8'h01;
                     next_oe = 1'b1;
                     next_st = ST_WR_ACK;
                  end
               end
            end
            ST_ADDR_ACK, ST_SUB_ACK, ST_WR_ACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0;
                  if (st == ST_ADDR_ACK && rw) begin
                     next_sh = read_byte(ptr);
                     next_oe = !next_sh[7];
                     next_st = ST_RD;
                  end else if (st == ST_ADDR_ACK) begin
                     next_st = ST_SUB;
                  end else begin
                     next_st = ST_WR;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  next_cnt = cnt + 4'h1;
                  if (cnt == 4'h7) begin
                     next_oe = 1'b0;
                     next_st = ST_RD_ACK;
                  end else begin
                     next_sh = {sh[6:0], 1'b1};
                     next_oe = !sh[6];
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  next_nack = sda_s;
               end else if (scl_fall) begin
                  if (nack) begin
                     next_st = ST_IDLE;
                  end else begin
                     next_ptr = ptr + 8'h01;
                     next_sh = read_byte(next_ptr);
                     next_oe = !next_sh[7];
                     next_cnt = 4'h0;
                     next_st = ST_RD;
                  end
               end
            end
            default: begin
               next_st = ST_IDLE;
            end
         endcase
      end
      // one unlock buys exactly one write; any other write relocks
      if (wr_fire) begin
         if (ptr == rail_seq_pkg::SUBADDR_UNLOCK && sh == UNLOCK_KEY) begin
            next_unlocked = 1'b1;
         end else begin
            next_unlocked = 1'b0;
            if (unlocked && ptr == rail_seq_pkg::SUBADDR_SLOT_SW) begin
               next_slot_sw = sh;
            end
            if (unlocked && ptr == rail_seq_pkg::SUBADDR_SLOT_GP) begin
               next_slot_gp = sh;
            end
         end
      end
      // a step hit wins over a clear in the same cycle
      for (int i = 0; i < rail_seq_pkg::RAIL_COUNT; i++) begin
         if (bus.hit[i]) next_rail_on[i] = 1'b1;
         else if (seq_clear) next_rail_on[i] = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= ST_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         nack <= 1'b1;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         slot_sw <= rail_seq_pkg::RESET_SLOT_SW;
         slot_gp <= rail_seq_pkg::RESET_SLOT_GP;
         unlocked <= 1'b0;
         rail_on <= 4'h0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         sh <= next_sh;
         ptr <= next_ptr;
         rw <= next_rw;
         nack <= next_nack;
         sda_oe <= next_oe;
         sda_out <= 1'b0; // open drain: only ever pulls low
         slot_sw <= next_slot_sw;
         slot_gp <= next_slot_gp;
         unlocked <= next_unlocked;
         rail_on <= next_rail_on;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_switch_reg: assert property ($rose(rst_n) |-> slot_sw == 8'h88)
      else $error("switch and regulator register left reset wrong");
   a_reset_output_reg: assert property ($rose(rst_n) |-> slot_gp == 8'h08)
      else $error("general output register left reset wrong");
   a_locked_write_drop: assert property ((wr_fire && !unlocked) |=>
      slot_sw == $past(slot_sw) && slot_gp == $past(slot_gp))
      else $error("step register changed while locked");
   a_unlock_single_use: assert property ((wr_fire && unlocked &&
      ptr != 8'h10) |=> !unlocked)
      else $error("unlock survived a write");
   a_rail_rise_cause: assert property ($rose(rail_on[0]) |-> $past(step_strobe) &&
      $past(step_num) == $past(slot_sw[7:4]))
      else $error("switch rail came on without its step");
   a_unsequenced_stays_off: assert property ((slot_gp[7:4] > 4'ha && !rail_on[3])
      |=> !rail_on[3])
      else $error("unsequenced output three came on");

   c_unlocked_write: cover property (wr_fire && unlocked && ptr == 8'h25);
   c_read_continue: cover property (st == ST_RD_ACK && scl_fall && !nack);
   c_regulator_on: cover property ($rose(rail_on[1]));
endmodule
`default_nettype wire

// *** i2c_host.sv ***
`default_nettype none
// host side of the two-wire bus; every pin change lands on a rising clk edge
module i2c_host (
   input wire logic clk,
   input wire logic sda_line,
   output var logic scl,
   output var logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idles with sda released to the pull-up and scl driven high by the host
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // -------------------------------------------------------------
   // framing
   // -------------------------------------------------------------
   // serves as first start and as repeated start: release, raise clock, pull data
   task automatic start();
      sda_low <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(12);
      sda_low <= 1'b1;
      tick(12);
      scl <= 1'b0;
      tick(6);
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(12);
      sda_low <= 1'b0;
      tick(12);
   endtask

   // -------------------------------------------------------------
   // bits and bytes
   // -------------------------------------------------------------
   // six cycles of hold and setup keep data clear of the target's synchronisers
   task automatic bit_io(input logic b, output logic r);
      sda_low <= !b;
      tick(6);
      scl <= 1'b1;
      tick(12);
      r = sda_line;
      scl <= 1'b0;
      tick(6);
   endtask

   // msb first, then the ninth bit; sending ff hands the line to the target
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(mack, ack);
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
`define CHK(a, e) begin \
   comparisons++; \
   if ((a) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
   end \
end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] taddr = 7'h2a;
   localparam logic [7:0] key = 8'h5a;
   localparam logic [7:0] sw = 8'h25;
   localparam logic [7:0] gp = 8'h26;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic step_strobe = 1'b0;
   logic [3:0] step_num = 4'h0;
   logic seq_clear = 1'b0;
   logic scl, sda_low, sda_out, sda_oe, sda_line;
   logic [3:0] rail_on;
   logic [7:0] rd;
   logic [15:0] rd2;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;

   // open drain with a pull-up: low while either party pulls
   assign sda_line = !(sda_low || (sda_oe && !sda_out));
   always #5 clk = ~clk;

   i2c_host i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   rail_sequence_slot_regs #(.TARGET_ADDR(taddr), .UNLOCK_KEY(key)) i_dut (
      .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .step_strobe(step_strobe), .step_num(step_num),
      .seq_clear(seq_clear), .rail_on(rail_on));

   // -------------------------------------------------------------
   // access tasks
   // -------------------------------------------------------------
   task automatic wb(input logic [7:0] d);
      logic [7:0] rx;
      logic ack;
      i_host.xfer(d, 1'b1, rx, ack);
      `CHK(ack, 1'b0)
   endtask

   task automatic raw_wr(input logic [7:0] sub, input logic [7:0] d);
      i_host.start();
      wb({taddr, 1'b0});
      wb(sub);
      wb(d);
      i_host.stop();
   endtask

   // the key is used up by the next write, so each update carries its own
   task automatic reg_wr(input logic [7:0] sub, input logic [7:0] d);
      raw_wr(rail_seq_pkg::SUBADDR_UNLOCK, key);
      raw_wr(sub, d);
   endtask

   task automatic reg_rd(input logic [7:0] sub, output logic [7:0] d);
      logic ack;
      i_host.start();
      wb({taddr, 1'b0});
      wb(sub);
      i_host.start();
      wb({taddr, 1'b1});
      i_host.xfer(8'hff, 1'b1, d, ack);
      i_host.stop();
   endtask

   // burst of two neighbours: an ack after the first byte asks for the next place
   task automatic reg_rd2(input logic [7:0] sub, output logic [15:0] d);
      logic ack;
      i_host.start();
      wb({taddr, 1'b0});
      wb(sub);
      i_host.start();
      wb({taddr, 1'b1});
      i_host.xfer(8'hff, 1'b0, d[15:8], ack);
      i_host.xfer(8'hff, 1'b1, d[7:0], ack);
      i_host.stop();
   endtask

   // strobe is taken on the second edge; look at the outputs half a cycle later
   task automatic strobe(input logic [3:0] s);
      @(posedge clk);
      step_strobe <= 1'b1;
      step_num <= s;
      @(posedge clk);
      step_strobe <= 1'b0;
      @(negedge clk);
   endtask

   task automatic clear();
      @(posedge clk);
      seq_clear <= 1'b1;
      @(posedge clk);
      seq_clear <= 1'b0;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // the tests need about 77k cycles; past the ceiling something hangs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 100000) begin
         errors++;
         print_verdict();
      end
   end

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      // reset contents, an unmapped place, and the default step map
      reg_rd(sw, rd);
      `CHK(rd, 8'h88)
      reg_rd(gp, rd);
      `CHK(rd, 8'h08)
      reg_rd(8'h30, rd);
      `CHK(rd, 8'h00)
      reg_rd2(sw, rd2);
      `CHK(rd2, 16'h8808)
      strobe(4'h8);
      `CHK(rail_on, 4'h7)
      // the unlock latch reads back; a wrong key locks again
      raw_wr(rail_seq_pkg::SUBADDR_UNLOCK, key);
      reg_rd(rail_seq_pkg::SUBADDR_UNLOCK, rd);
      `CHK(rd, 8'h01)
      raw_wr(rail_seq_pkg::SUBADDR_UNLOCK, ~key);
      reg_rd(rail_seq_pkg::SUBADDR_UNLOCK, rd);
      `CHK(rd, 8'h00)
      // a write without the key must not land
      raw_wr(sw, 8'h33);
      reg_rd(sw, rd);
      `CHK(rd, 8'h88)
      // one key buys one write; each rail follows its own field
      reg_wr(sw, 8'h34);
      raw_wr(gp, 8'h65);
      reg_rd(gp, rd);
      `CHK(rd, 8'h08)
      reg_wr(gp, 8'h65);
      clear();
      strobe(4'h3);
      `CHK(rail_on, 4'h1)
      strobe(4'h4);
      `CHK(rail_on, 4'h3)
      strobe(4'h5);
      `CHK(rail_on, 4'h7)
      // a step hit in the same cycle as a clear keeps its own rail on
      @(posedge clk);
      seq_clear <= 1'b1;
      step_strobe <= 1'b1;
      step_num <= 4'h6;
      @(posedge clk);
      seq_clear <= 1'b0;
      step_strobe <= 1'b0;
      @(negedge clk);
      `CHK(rail_on, 4'h8)
      // a reset in mid-run brings back both defaults and drops the rails
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      reg_rd2(sw, rd2);
      `CHK(rd2, 16'h8808)
      `CHK(rail_on, 4'h0)
      // every code in all four fields, then a sweep over all sixteen steps
      for (int c = 0; c < 16; c++) begin
         reg_wr(sw, {c[3:0], c[3:0]});
         reg_wr(gp, {c[3:0], c[3:0]});
         reg_rd(sw, rd);
         `CHK(rd, {c[3:0], c[3:0]})
         clear();
         for (int s = 0; s < 16; s++) begin
            strobe(s[3:0]);
            `CHK(rail_on, (c >= 3 && c <= 10 && s >= c) ? 4'hf : 4'h0)
         end
      end
      print_verdict();
   end
endmodule
`undef CHK
`default_nettype wire
